// ### core/rcpg_pkg.sv
package rcpg_pkg;
   // ==========================================================
   // Address map and code values
   localparam logic [15:0] RCPG_CODE_ADDR = 16'hffdb;
   localparam logic [15:0] RCPG_AREA1_TOP = 16'hefff;
   localparam logic [7:0] RCPG_CODE_ALL = 8'h00;
   localparam logic [7:0] RCPG_CODE_AREA1 = 8'hfe;
   localparam logic [7:0] RCPG_CODE_NONE = 8'hff;

   // ==========================================================
   // Types
   typedef enum logic [1:0]
   {
      RCPG_FETCH = 2'b00,
      RCPG_WAIT = 2'b01,
      RCPG_READY = 2'b11
   } rcpg_state_type;

   typedef enum logic [1:0]
   {
      RCPG_PROT_NONE = 2'b00,
      RCPG_PROT_AREA1 = 2'b01,
      RCPG_PROT_ALL = 2'b10
   } rcpg_prot_type;

   typedef struct packed
   {
      logic valid;
      logic write;
      logic [15:0] addr;
      logic [7:0] wdata;
   } rcpg_req_type;

   typedef struct packed
   {
      logic valid;
      logic refused;
      logic [7:0] rdata;
   } rcpg_rsp_type;
endpackage

// ### core/rcpg_gate.sv
// Contract
// R01: The byte at the fixed protect address is the protect code.
// R02: Enabling codes refuse programmer reads and writes of covered region.
// R03: Partial region runs from ROM start through the upper boundary.
// R04: One code protects all, one protects partial region, one none; the gate protects all for every code other than ff and fe.
// R05: ROM image must hold the disabled value at the code location.
// R06: Software initialises RAM before use; contents undefined after reset.
// R07: Code is evaluated before any access and applies to all of them.
module rcpg_gate
   import rcpg_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire rcpg_req_type i_prog_req,
   output logic o_prog_ready,
   output rcpg_rsp_type o_prog_rsp,
   output logic o_rom_en,
   output logic o_rom_we,
   output logic [15:0] o_rom_addr,
   output logic [7:0] o_rom_wdata,
   input wire logic [7:0] i_rom_rdata,
   output rcpg_prot_type o_prot_mode,
   output logic o_code_valid
);
   // ==========================================================
   // Protect decoding
   function automatic rcpg_prot_type decode_code(input logic [7:0] code);
      rcpg_prot_type m;
      m = RCPG_PROT_ALL;
      if (code == RCPG_CODE_NONE)
      begin
         m = RCPG_PROT_NONE;
      end
      else if (code == RCPG_CODE_AREA1)
      begin
         m = RCPG_PROT_AREA1;
      end
      return m; // [R04]
   endfunction

   function automatic logic is_blocked(input rcpg_prot_type m,
                                       input logic [15:0] a);
      logic b;
      b = 1'b0;
      if (m == RCPG_PROT_ALL)
      begin
         b = 1'b1; // [R02]
      end
      else if (m == RCPG_PROT_AREA1)
      begin
         b = (a <= RCPG_AREA1_TOP); // [R03]
      end
      return b;
   endfunction

   rcpg_state_type state;
   rcpg_state_type next_state;
   rcpg_prot_type prot;
   rcpg_rsp_type rsp;
   logic pend;
   logic pend_write;

   // ==========================================================
   // Request decode
   wire logic ready_w = (state == RCPG_READY) && !pend; // [R07]
   wire logic take_w = i_ce && ready_w && i_prog_req.valid;
   wire logic block_w = is_blocked(prot, i_prog_req.addr);
   wire logic fetch_w = i_ce && (state == RCPG_FETCH);

   assign o_prog_ready = ready_w;
   assign o_prog_rsp = rsp;
   assign o_prot_mode = prot;
   assign o_code_valid = (state == RCPG_READY);
   assign o_rom_en = fetch_w || (take_w && !block_w); // [R02]
   assign o_rom_we = take_w && !block_w && i_prog_req.write;
   assign o_rom_addr = fetch_w ? RCPG_CODE_ADDR : i_prog_req.addr; // [R01]
   assign o_rom_wdata = i_prog_req.wdata;

   always_comb
   begin
      next_state = state;
      case (state)
         RCPG_FETCH: next_state = RCPG_WAIT;
         RCPG_WAIT: next_state = RCPG_READY;
         default: next_state = RCPG_READY;
      endcase
   end

   // ==========================================================
   // State and responses
   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         state <= RCPG_FETCH;
         prot <= RCPG_PROT_ALL;
         pend <= 1'b0;
         pend_write <= 1'b0;
         rsp <= '0;
      end
      else if (i_ce)
      begin
         state <= next_state;
         rsp.valid <= 1'b0;
         if (state == RCPG_WAIT)
         begin
            prot <= decode_code(i_rom_rdata); // [R01] [R07]
         end
         pend <= take_w && !block_w && !i_prog_req.write;
         pend_write <= 1'b0;
         if (take_w && (block_w || i_prog_req.write))
         begin
            rsp.valid <= 1'b1;
            rsp.refused <= block_w; // [R02]
            rsp.rdata <= '0;
         end
         else if (pend)
         begin
            rsp.valid <= 1'b1;
            rsp.refused <= 1'b0;
            rsp.rdata <= i_rom_rdata;
         end
      end
   end
endmodule

// ### bench/rcpg_rom_model.sv
module rcpg_rom_model
   import rcpg_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_en,
   input wire logic [15:0] i_addr,
   input wire logic [7:0] i_code,
   output logic [7:0] o_rdata
);
timeunit 1ns;
timeprecision 1ns;
// Sync ROM; an idle bus flips so stale data never matches
always @(posedge i_clk)
   o_rdata <= !i_en ? ~o_rdata : i_addr == RCPG_CODE_ADDR ? i_code
      : i_addr[15:8] ^ i_addr[7:0];
endmodule

// ### bench/rcpg_gate_properties.sv
module rcpg_gate_chk
   import rcpg_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire logic o_prog_ready,
   input wire logic o_rom_en,
   input wire logic o_rom_we,
   input wire logic [7:0] o_rom_wdata,
   input wire logic o_code_valid,
   input wire rcpg_req_type i_prog_req,
   input wire rcpg_rsp_type o_prog_rsp,
   input wire logic [15:0] o_rom_addr,
   input wire logic [7:0] i_rom_rdata,
   input wire rcpg_prot_type o_prot_mode
);
default clocking @(posedge i_core_clk); endclocking
default disable iff (i_srst);
chk_code_fetch: assert property
   ($fell(i_srst) |-> o_rom_en && o_rom_addr == RCPG_CODE_ADDR)
   else $error("code fetch missing");
chk_mode_decode: assert property
   ($rose(o_code_valid) |-> o_prot_mode ==
   ($past(i_rom_rdata) == RCPG_CODE_NONE ? RCPG_PROT_NONE :
   $past(i_rom_rdata) == RCPG_CODE_AREA1 ? RCPG_PROT_AREA1 : RCPG_PROT_ALL))
   else $error("bad mode decode");
chk_block_strobe: assert property
   (o_rom_en && o_code_valid |-> o_prot_mode == RCPG_PROT_NONE ||
   o_prot_mode == RCPG_PROT_AREA1 && o_rom_addr > RCPG_AREA1_TOP)
   else $error("strobe in blocked area");
chk_refuse_answer: assert property
   (i_ce && o_prog_ready && i_prog_req.valid && !o_rom_en
   |=> o_prog_rsp.valid && o_prog_rsp.refused)
   else $error("refusal missing");
chk_mode_hold: assert property
   (o_code_valid |=> $stable(o_prot_mode))
   else $error("mode changed");
chk_write_strobe: assert property
   (o_rom_we |-> o_rom_en && i_prog_req.write &&
   o_rom_wdata == i_prog_req.wdata)
   else $error("bad write strobe");
cover property (o_prog_rsp.valid && o_prog_rsp.refused);
cover property (o_prog_rsp.valid && !o_prog_rsp.refused);
cover property (o_prot_mode == RCPG_PROT_AREA1);
endmodule
bind rcpg_gate rcpg_gate_chk u_chk (.*);

// ### bench/rcpg_gate_tb.sv
module rcpg_gate_tb;
import rcpg_pkg::*;
timeunit 1ns;
timeprecision 1ns;
logic clk = 0, srst = 1, rdy, en;
rcpg_req_type req = '0;
logic [1:0] pm;
rcpg_rsp_type rsp;
logic [15:0] ra;
logic [7:0] rd, code = 8'hff;
logic [7:0] codes[$] = '{8'hff, 8'hfe, 8'h00, 8'h5a}; // ff first
logic [15:0] as[$];
int err_total, n_tests, seed = 61546, cyc;
always #4 clk = ~clk;
rcpg_gate dut(.i_core_clk(clk), .i_srst(srst), .i_ce(1'b1),
   .i_prog_req(req), .o_prog_ready(rdy), .o_prog_rsp(rsp), .o_rom_en(en),
   .o_rom_we(), .o_rom_addr(ra), .o_rom_wdata(), .i_rom_rdata(rd),
   .o_prot_mode(pm), .o_code_valid());
rcpg_rom_model rom(.i_clk(clk), .i_en(en), .i_addr(ra), .i_code(code),
   .o_rdata(rd));
task give_verdict;
   $display("checks %0d errors %0d", n_tests, err_total);
   if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
   else
      $display("SIMULATION FAILED");
   $finish;
endtask
task chk(string s, logic [9:0] v, e);
   n_tests++;
   if (v !== e)
   begin
      err_total++;
      $display("wrong value %s exp %h got %h", s, e, v);
   end
endtask
task xfer(logic w, logic [15:0] a);
   logic b;
   @(negedge clk) req <= '{1'b1, w, a, 8'h3c};
   while (rdy !== 1) @(negedge clk);
   @(negedge clk) req.valid <= 0;
   for (int k = 0; k < 3 && rsp.valid !== 1; k++) @(negedge clk);
   b = code != RCPG_CODE_NONE && (code != RCPG_CODE_AREA1 ||
      a <= RCPG_AREA1_TOP);
   chk("resp", {rsp.valid, rsp.refused, w ? 8'h0 : rsp.rdata},
      {1'b1, b, b | w ? 8'h0 : a == RCPG_CODE_ADDR ? code
      : a[15:8] ^ a[7:0]});
endtask
always @(posedge clk)
   if (++cyc > 3000)
   begin
      err_total++;
      give_verdict;
   end
initial
begin
   foreach (codes[i])
   begin
      code = codes[i];
      srst = 1;
      repeat (2) @(negedge clk);
      srst = 0;
      as = '{16'h0, 16'hefff, 16'hf000, RCPG_CODE_ADDR, 16'hffff,
         16'($random(seed))};
      foreach (as[j])
      begin
         xfer(0, as[j]);
         xfer(1, as[j]);
         xfer(0, as[j]);
      end
      chk("mode", {8'h0, pm}, {8'h0, code == RCPG_CODE_NONE ? 2'h0
         : code == RCPG_CODE_AREA1 ? 2'h1 : 2'h2});
      $display("code %h done", code);
   end
   give_verdict;
end
endmodule
